// ---- design/acr_pkg.sv ----
// constants and carrier types for the clock, range and power register slice
`default_nettype none
package acr_pkg;
  // ----------------------------------------------------------------
  // register port geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // byte offsets; multi-byte registers put their low byte first
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_NOISE_CTRL = 8'h2b;
  localparam logic [7:0] OFS_EDGE_POS_0 = 8'h2c;
  localparam logic [7:0] OFS_EDGE_POS_1 = 8'h2d;
  localparam logic [7:0] OFS_EDGE_POS_2 = 8'h2e;
  localparam logic [7:0] OFS_FSR_LO = 8'h30;
  localparam logic [7:0] OFS_FSR_HI = 8'h31;
  localparam logic [7:0] OFS_PWR_MODE_ONE = 8'h37;
  localparam logic [7:0] OFS_TIMESTAMP_INPUT_CONTROL = 8'h3b;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ANALOG_NS = 2;
  localparam int unsigned BIT_CLOCK_NS = 0;
  localparam int unsigned BIT_TIMESTAMP_INPUT_PECL = 1;
  localparam int unsigned BIT_TIMESTAMP_INPUT_RECV = 0;
  localparam int unsigned EDGE_POS_W = 24;
  localparam int unsigned FSR_W = 16;

  // ----------------------------------------------------------------
  // values after reset and accepted codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_NOISE_CTRL = 8'h00;
  localparam logic [23:0] RST_EDGE_POS = 24'h000000;
  localparam logic [15:0] RST_FSR = 16'ha000;
  localparam logic [7:0] RST_TIMESTAMP_INPUT_CONTROL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  typedef enum logic [7:0] {
    PWR_LOW_POWER = 8'h46,
    PWR_HIGH_PERF = 8'h4b
  } acr_pwr_mode_e;

  localparam acr_pwr_mode_e RST_PWR_MODE_ONE = PWR_HIGH_PERF;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } acr_req_s;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } acr_rsp_s;

  typedef struct packed {
    logic analog_rail_noise_suppress_en;
    logic clock_rail_noise_suppress_en;
    logic [FSR_W-1:0] full_scale_range;
    logic [7:0] power_mode_code_one;
    logic low_power_mode;
    logic timestamp_pecl_mode_en;
    logic timestamp_receiver_en;
  } acr_ctrl_s;
endpackage
`default_nettype wire

// ---- design/acr_regs.sv ----
// clock, full-scale range, power mode and timestamp control register slice
`default_nettype none
// Overview of operation
// - bit 2 enables analog rail noise suppression
// - bit 0 enables clock rail noise suppression
// - read-only 24-bit edge position, resets zero
// - 16-bit full-scale code, all channels, reset 0xa000
// - power mode accepts 0x46 or 0x4b only
// - timestamp bit 1 selects pecl termination mode
// - timestamp bit 0 enables receiver, off at reset
module acr_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire acr_pkg::acr_req_s req,
  input wire logic [acr_pkg::EDGE_POS_W-1:0] sysref_edge_position_in,
  output var acr_pkg::acr_rsp_s rsp,
  output var acr_pkg::acr_ctrl_s ctrl
);
  import acr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] noise_q, noise_d;
  logic [EDGE_POS_W-1:0] pos_q, pos_d;
  logic [FSR_W-1:0] fsr_q, fsr_d;
  acr_pwr_mode_e pwr_q, pwr_d;
  logic [7:0] timestamp_input_q, timestamp_input_d;
  logic low_q, low_d;
  acr_rsp_s rsp_q, rsp_d;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (req.addr)
      OFS_NOISE_CTRL: rd_byte = noise_q;
      OFS_EDGE_POS_0: rd_byte = pos_q[7:0];
      OFS_EDGE_POS_1: rd_byte = pos_q[15:8];
      OFS_EDGE_POS_2: rd_byte = pos_q[23:16];
      OFS_FSR_LO: rd_byte = fsr_q[7:0];
      OFS_FSR_HI: rd_byte = fsr_q[15:8];
      OFS_PWR_MODE_ONE: rd_byte = pwr_q;
      OFS_TIMESTAMP_INPUT_CONTROL: rd_byte = timestamp_input_q;
      default: rd_byte = RD_UNMAPPED;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    noise_d = noise_q;
    fsr_d = fsr_q;
    pwr_d = pwr_q;
    timestamp_input_d = timestamp_input_q;
    // status tracks the detector every cycle; writes to it go nowhere
    pos_d = sysref_edge_position_in;
    rsp_d.valid = req.rd;
    rsp_d.data = req.rd ? rd_byte : RD_UNMAPPED;
    if (req.wr) begin
      case (req.addr)
        // reserved bits are stored as written so read-back stays honest
        OFS_NOISE_CTRL: noise_d = req.wdata;
        OFS_FSR_LO: fsr_d[7:0] = req.wdata;
        OFS_FSR_HI: fsr_d[15:8] = req.wdata;
        OFS_PWR_MODE_ONE: begin
          // a reserved code is dropped rather than driving an undefined mode
          if (req.wdata == PWR_LOW_POWER || req.wdata == PWR_HIGH_PERF) begin
            pwr_d = acr_pwr_mode_e'(req.wdata);
          end
        end
        OFS_TIMESTAMP_INPUT_CONTROL: timestamp_input_d = req.wdata;
        default: begin
        end
      endcase
    end
    // decoded ahead of the flop so the mode flag leaves on a register in step with the code
    low_d = (pwr_d == PWR_LOW_POWER);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      noise_q <= RST_NOISE_CTRL;
      pos_q <= RST_EDGE_POS;
      fsr_q <= RST_FSR;
      pwr_q <= RST_PWR_MODE_ONE;
      timestamp_input_q <= RST_TIMESTAMP_INPUT_CONTROL;
      low_q <= (RST_PWR_MODE_ONE == PWR_LOW_POWER);
      rsp_q <= '0;
    end else begin
      noise_q <= noise_d;
      pos_q <= pos_d;
      fsr_q <= fsr_d;
      pwr_q <= pwr_d;
      timestamp_input_q <= timestamp_input_d;
      low_q <= low_d;
      rsp_q <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state flops
  // ----------------------------------------------------------------
  assign rsp = rsp_q;
  always_comb begin
    ctrl.analog_rail_noise_suppress_en = noise_q[BIT_ANALOG_NS];
    ctrl.clock_rail_noise_suppress_en = noise_q[BIT_CLOCK_NS];
    ctrl.full_scale_range = fsr_q;
    ctrl.power_mode_code_one = pwr_q;
    ctrl.low_power_mode = low_q;
    ctrl.timestamp_pecl_mode_en = timestamp_input_q[BIT_TIMESTAMP_INPUT_PECL];
    ctrl.timestamp_receiver_en = timestamp_input_q[BIT_TIMESTAMP_INPUT_RECV];
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_analog_ns;
    @(posedge clk) disable iff (!rstn)
      req.wr && req.addr == OFS_NOISE_CTRL |=>
        ctrl.analog_rail_noise_suppress_en == $past(req.wdata[BIT_ANALOG_NS]);
  endproperty
  a_analog_ns: assert property (p_analog_ns) else $error("analog rail enable wrong");

  property p_clock_ns;
    @(posedge clk) disable iff (!rstn)
      req.wr && req.addr == OFS_NOISE_CTRL |=>
        ctrl.clock_rail_noise_suppress_en == $past(req.wdata[BIT_CLOCK_NS]);
  endproperty
  a_clock_ns: assert property (p_clock_ns) else $error("clock rail enable wrong");

  property p_edge_pos_read;
    @(posedge clk) disable iff (!rstn)
      req.rd && req.addr == OFS_EDGE_POS_2 |-> ##1 rsp.valid ##0
        rsp.data == $past(sysref_edge_position_in[23:16], 2);
  endproperty
  a_edge_pos_read: assert property (p_edge_pos_read)
    else $error("edge position read wrong");

  property p_fsr_write;
    @(posedge clk) disable iff (!rstn)
      req.wr && req.addr == OFS_FSR_HI |=>
        ctrl.full_scale_range[15:8] == $past(req.wdata) && $stable(ctrl.full_scale_range[7:0]);
  endproperty
  a_fsr_write: assert property (p_fsr_write) else $error("full-scale write wrong");

  property p_fsr_lo_write;
    @(posedge clk) disable iff (!rstn)
      req.wr && req.addr == OFS_FSR_LO |=>
        ctrl.full_scale_range[7:0] == $past(req.wdata) && $stable(ctrl.full_scale_range[15:8]);
  endproperty
  a_fsr_lo_write: assert property (p_fsr_lo_write)
    else $error("full-scale low byte write wrong");

  property p_pwr_legal;
    @(posedge clk) disable iff (!rstn)
      ctrl.power_mode_code_one == PWR_LOW_POWER || ctrl.power_mode_code_one == PWR_HIGH_PERF;
  endproperty
  a_pwr_legal: assert property (p_pwr_legal) else $error("power mode holds reserved code");

  property p_pwr_reserved_ignored;
    @(posedge clk) disable iff (!rstn)
      req.wr && req.addr == OFS_PWR_MODE_ONE && req.wdata != PWR_LOW_POWER
        && req.wdata != PWR_HIGH_PERF |=> $stable(ctrl.power_mode_code_one);
  endproperty
  a_pwr_reserved_ignored: assert property (p_pwr_reserved_ignored)
    else $error("reserved code taken");

  // the mode flag is a flop of its own, so keep it in step with the code
  property p_low_power_flag;
    @(posedge clk) disable iff (!rstn)
      ctrl.low_power_mode == (ctrl.power_mode_code_one == PWR_LOW_POWER);
  endproperty
  a_low_power_flag: assert property (p_low_power_flag)
    else $error("low power flag out of step");

  property p_timestamp_input_pecl;
    @(posedge clk) disable iff (!rstn)
      req.wr && req.addr == OFS_TIMESTAMP_INPUT_CONTROL |=>
        ctrl.timestamp_pecl_mode_en == $past(req.wdata[BIT_TIMESTAMP_INPUT_PECL]);
  endproperty
  a_timestamp_input_pecl: assert property (p_timestamp_input_pecl) else $error("pecl mode enable wrong");

  property p_timestamp_input_recv;
    @(posedge clk) disable iff (!rstn)
      $rose(ctrl.timestamp_receiver_en) |->
        $past(req.wr && req.addr == OFS_TIMESTAMP_INPUT_CONTROL && req.wdata[BIT_TIMESTAMP_INPUT_RECV]);
  endproperty
  a_timestamp_input_recv: assert property (p_timestamp_input_recv)
    else $error("receiver enabled without write");

  property p_readback;
    @(posedge clk) disable iff (!rstn)
      req.wr && req.addr == OFS_TIMESTAMP_INPUT_CONTROL ##1 req.rd && !req.wr && req.addr == OFS_TIMESTAMP_INPUT_CONTROL
        |=> rsp.valid && rsp.data == $past(req.wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("read-back mismatch");

  property p_rsp_valid;
    @(posedge clk) disable iff (!rstn)
      req.rd |=> rsp.valid;
  endproperty
  a_rsp_valid: assert property (p_rsp_valid)
    else $error("read answer missing");

  property p_rsp_idle;
    @(posedge clk) disable iff (!rstn)
      !req.rd |=> !rsp.valid && rsp.data == RD_UNMAPPED;
  endproperty
  a_rsp_idle: assert property (p_rsp_idle)
    else $error("answer without read");

  c_low_power: cover property (@(posedge clk) disable iff (!rstn) $rose(ctrl.low_power_mode));
  c_fsr_min: cover property (@(posedge clk) disable iff (!rstn)
    ctrl.full_scale_range == 16'h2000);
  c_recv_on: cover property (@(posedge clk) disable iff (!rstn)
    ctrl.timestamp_receiver_en && ctrl.timestamp_pecl_mode_en);
  c_back_to_back: cover property (@(posedge clk) disable iff (!rstn)
    req.wr && req.addr == OFS_TIMESTAMP_INPUT_CONTROL ##1 req.rd && req.addr == OFS_TIMESTAMP_INPUT_CONTROL);
endmodule
`default_nettype wire

// ---- sim/acr_host.sv ----
// host model driving byte writes and reads on the register port
`default_nettype none
module acr_host (
  input wire logic clk,
  output var acr_pkg::acr_req_s req,
  input wire acr_pkg::acr_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // released address and data show the inverse, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // answer is registered, so it is taken one cycle after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    v = rsp.valid;
    d = rsp.data;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask
  // write, then read the same byte on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d,
    output logic v);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~wd};
    @(negedge clk);
    v = rsp.valid;
    d = rsp.data;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask
  // mode change: enables cleared first, the other three mode registers and the
  // calibration afterwards all live outside this slice
  task automatic wr_pwr(input logic [7:0] d);
    wr(acr_pkg::OFS_PWR_MODE_ONE, d);
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_adc_clock_range_power_regs.sv ----
// self-checking bench for the clock, range and power register slice
`default_nettype none
module tb_adc_clock_range_power_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import acr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [23:0] pos = '0;
  acr_req_s req;
  acr_rsp_s rsp;
  acr_ctrl_s ctrl;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h6582;
  logic [7:0] w, pm, d, hi;
  logic [23:0] st;
  logic v;
  logic [7:0] rst_a [8] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h30, 8'h31, 8'h37, 8'h3b};
  logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, 8'h4b, 8'h00};
  acr_regs acr_regs_inst (.clk(clk), .rstn(rstn), .req(req), .sysref_edge_position_in(pos),
    .rsp(rsp), .ctrl(ctrl));
  acr_host acr_host_inst (.clk(clk), .req(req), .rsp(rsp));
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reserved power codes leave the stored mode untouched
  function automatic logic [7:0] pwr_exp(input logic [7:0] old, input logic [7:0] wv);
    return (wv == 8'h46 || wv == 8'h4b) ? wv : old;
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    acr_host_inst.rd(a, d, v);
    chk({15'h0, v, d}, {15'h0, 1'b1, e});
  endtask
  task automatic rst_chk;
    chk({ctrl.analog_rail_noise_suppress_en, ctrl.clock_rail_noise_suppress_en,
      ctrl.low_power_mode, ctrl.timestamp_pecl_mode_en, ctrl.timestamp_receiver_en,
      ctrl.power_mode_code_one}, {5'h00, 8'h4b});
    chk(ctrl.full_scale_range, 16'ha000);
    foreach (rst_a[i]) rchk(rst_a[i], rst_v[i]);
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    rst_chk();
    for (int i = 0; i < 24; i++) begin
      seed = nxt(seed);
      w = seed[7:0] & 8'h05;
      acr_host_inst.wr(OFS_NOISE_CTRL, w);
      chk({ctrl.analog_rail_noise_suppress_en, ctrl.clock_rail_noise_suppress_en},
        {w[2], w[0]});
      rchk(OFS_NOISE_CTRL, w);
      acr_host_inst.wr(OFS_TIMESTAMP_INPUT_CONTROL, {6'h00, seed[9:8]});
      chk({ctrl.timestamp_pecl_mode_en, ctrl.timestamp_receiver_en}, seed[9:8]);
      acr_host_inst.wr_rd(OFS_TIMESTAMP_INPUT_CONTROL, {6'h00, seed[11:10]}, d, v);
      chk({15'h0, v, d}, {15'h0, 1'b1, 6'h00, seed[11:10]});
      chk({ctrl.timestamp_pecl_mode_en, ctrl.timestamp_receiver_en}, seed[11:10]);
      hi = seed[31:24] | 8'h20;
      acr_host_inst.wr(OFS_FSR_LO, seed[23:16]);
      acr_host_inst.wr(OFS_FSR_HI, hi);
      chk(ctrl.full_scale_range, {hi, seed[23:16]});
      rchk(OFS_FSR_HI, hi);
      rchk(OFS_FSR_LO, seed[23:16]);
      pos = seed[23:0] ^ 24'h5a5a5a;
      acr_host_inst.wr(OFS_EDGE_POS_1, ~pos[15:8]);
      for (int b = 0; b < 3; b++) begin
        rchk(8'(OFS_EDGE_POS_0 + b), pos[8*b +: 8]);
        st[8*b +: 8] = d;
      end
      // the host sets its 4-bit delay select, outside this slice, from this word
      chk(st, pos);
    end
    pm = 8'h4b;
    for (int i = 0; i < 12; i++) begin
      seed = nxt(seed);
      w = i[0] ? seed[7:0] : (i[1] ? 8'h4b : 8'h46);
      acr_host_inst.wr_pwr(w);
      pm = pwr_exp(pm, w);
      chk({ctrl.low_power_mode, ctrl.power_mode_code_one}, {pm == 8'h46, pm});
      rchk(OFS_PWR_MODE_ONE, pm);
    end
    acr_host_inst.wr(8'h32, 8'h5a);
    rchk(8'h32, 8'h00);
    // full-scale corners: recommended minimum and maximum codes
    acr_host_inst.wr(OFS_FSR_LO, 8'h00);
    acr_host_inst.wr(OFS_FSR_HI, 8'h20);
    chk(ctrl.full_scale_range, 16'h2000);
    acr_host_inst.wr(OFS_FSR_LO, 8'hff);
    acr_host_inst.wr(OFS_FSR_HI, 8'hff);
    chk(ctrl.full_scale_range, 16'hffff);
    // reset again in mid-run: every register must fall back to its reset value
    pos = '0;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rst_chk();
    final_report();
  end
endmodule
`default_nettype wire
